// [rtl/led_channel_mode_pwm_control.sv]
// Purpose: Mode sequencer, register file and duty generator for four sinks
// Assumes: Serial framing decoded elsewhere into a byte register port
// Notes:   Pins are filtered by three flops; engines are external inputs
`timescale 1ns/100ps
module led_channel_mode_pwm_control #(
   parameter int DEV_ON_CYC = led_ctrl_pkg::DEV_ON_CYC,
   parameter int PIN_ON_CYC = led_ctrl_pkg::PIN_ON_CYC
) (
   input  wire logic       ref_clk_i,
   input  wire logic       rst_i,
   input  wire logic       power_on_pin_i,
   input  wire logic       overheat_cutoff_i,
   input  wire logic       power_save_req_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic [7:0] eng1_duty_i,
   input  wire logic [7:0] eng2_duty_i,
   input  wire logic [7:0] eng3_duty_i,
   input  wire logic [2:0] eng_direct_i,
   output logic      [7:0] reg_rdata_o,
   output logic      [3:0] led_pwm_o,
   output logic      [7:0] blue_sink_level_o,
   output logic      [7:0] green_sink_level_o,
   output logic      [7:0] red_sink_level_o,
   output logic      [7:0] white_sink_level_o,
   output logic            analog_enable_o,
   output logic      [4:0] op_mode_o
);

   // Refuse delays the counters cannot hold
   if (DEV_ON_CYC < 1 || DEV_ON_CYC >= (1 << led_ctrl_pkg::DLY_W) ||
       PIN_ON_CYC < 1 || PIN_ON_CYC >= (1 << led_ctrl_pkg::DLY_W))
   begin : g_bad_delay
      $error("startup delay parameter out of range");
   end

   localparam logic [16:0] DEV_ON_LIM = 17'(DEV_ON_CYC - 1);
   localparam logic [16:0] PIN_ON_LIM = 17'(PIN_ON_CYC - 1);
   localparam logic [10:0] SLOW_LIM   = 11'(led_ctrl_pkg::SLOW_DIV - 1);
   localparam logic [10:0] FAST_LIM   = 11'(led_ctrl_pkg::FAST_DIV - 1);

   // Pin filters: first flop feeds only the second
   logic [2:0] pin_sync_r;
   logic [2:0] heat_sync_r;
   logic       pin_filt_r;
   logic       pin_filt_nxt;
   logic       heat_filt_r;
   logic       heat_filt_nxt;

   always_comb
   begin
      pin_filt_nxt  = pin_filt_r;
      heat_filt_nxt = heat_filt_r;
      if (pin_sync_r[1] == pin_sync_r[2])
      begin
         pin_filt_nxt = pin_sync_r[2];
      end
      if (heat_sync_r[1] == heat_sync_r[2])
      begin
         heat_filt_nxt = heat_sync_r[2];
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pin_sync_r  <= 3'h0;
         heat_sync_r <= 3'h0;
         pin_filt_r  <= 1'b0;
         heat_filt_r <= 1'b0;
      end
      else
      begin
         pin_sync_r  <= {pin_sync_r[1:0], power_on_pin_i};
         heat_sync_r <= {heat_sync_r[1:0], overheat_cutoff_i};
         pin_filt_r  <= pin_filt_nxt;
         heat_filt_r <= heat_filt_nxt;
      end
   end

   // Register file
   logic [7:0] duty_r  [4];
   logic [7:0] duty_nxt[4];
   logic [7:0] level_r  [4];
   logic [7:0] level_nxt[4];
   logic [7:0] enable_r;
   logic [7:0] enable_nxt;
   logic [7:0] config_r;
   logic [7:0] config_nxt;
   logic [7:0] map_r;
   logic [7:0] map_nxt;
   logic [7:0] rdata_nxt;
   logic       soft_rst;
   logic       wr_ok;

   led_ctrl_pkg::op_mode_e mode_r;
   led_ctrl_pkg::op_mode_e mode_nxt;

   // Writes need the pin high; the key write restores defaults
   assign wr_ok    = reg_wr_i && pin_filt_r;
   assign soft_rst = wr_ok && reg_addr_i == led_ctrl_pkg::SOFT_RST_ADDR &&
                     reg_wdata_i == led_ctrl_pkg::SOFT_RST_KEY;

   always_comb
   begin
      duty_nxt   = duty_r;
      level_nxt  = level_r;
      enable_nxt = enable_r;
      config_nxt = config_r;
      map_nxt    = map_r;
      if (soft_rst)
      begin
         for (int i = 0; i < 4; i++)
         begin
            duty_nxt[i]  = led_ctrl_pkg::DUTY_RST;
            level_nxt[i] = led_ctrl_pkg::LEVEL_RST;
         end
         enable_nxt = led_ctrl_pkg::CTRL_RST;
         config_nxt = led_ctrl_pkg::CTRL_RST;
         map_nxt    = led_ctrl_pkg::MAP_RST;
      end
      else if (wr_ok)
      begin
         case (reg_addr_i)
            led_ctrl_pkg::ENABLE_ADDR:    enable_nxt   = reg_wdata_i;
            led_ctrl_pkg::BLUE_DUTY_ADDR: duty_nxt[0]  = reg_wdata_i;
            led_ctrl_pkg::GRN_DUTY_ADDR:  duty_nxt[1]  = reg_wdata_i;
            led_ctrl_pkg::RED_DUTY_ADDR:  duty_nxt[2]  = reg_wdata_i;
            led_ctrl_pkg::WHT_DUTY_ADDR:  duty_nxt[3]  = reg_wdata_i;
            led_ctrl_pkg::BLUE_LVL_ADDR:  level_nxt[0] = reg_wdata_i;
            led_ctrl_pkg::GRN_LVL_ADDR:   level_nxt[1] = reg_wdata_i;
            led_ctrl_pkg::RED_LVL_ADDR:   level_nxt[2] = reg_wdata_i;
            led_ctrl_pkg::WHT_LVL_ADDR:   level_nxt[3] = reg_wdata_i;
            led_ctrl_pkg::CONFIG_ADDR:    config_nxt   = reg_wdata_i;
            led_ctrl_pkg::SRC_MAP_ADDR:   map_nxt      = reg_wdata_i;
            default:                      enable_nxt   = enable_r;
         endcase
      end
      // Pin low drops the device-on bit, also wins over a same-cycle write
      if (!pin_filt_r)
      begin
         enable_nxt[led_ctrl_pkg::DEV_ON_BIT] = 1'b0;
      end
   end

   // Read data is captured on the read strobe
   always_comb
   begin
      rdata_nxt = reg_rdata_o;
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            led_ctrl_pkg::ENABLE_ADDR:    rdata_nxt = enable_r;
            led_ctrl_pkg::BLUE_DUTY_ADDR: rdata_nxt = duty_r[0];
            led_ctrl_pkg::GRN_DUTY_ADDR:  rdata_nxt = duty_r[1];
            led_ctrl_pkg::RED_DUTY_ADDR:  rdata_nxt = duty_r[2];
            led_ctrl_pkg::WHT_DUTY_ADDR:  rdata_nxt = duty_r[3];
            led_ctrl_pkg::BLUE_LVL_ADDR:  rdata_nxt = level_r[0];
            led_ctrl_pkg::GRN_LVL_ADDR:   rdata_nxt = level_r[1];
            led_ctrl_pkg::RED_LVL_ADDR:   rdata_nxt = level_r[2];
            led_ctrl_pkg::WHT_LVL_ADDR:   rdata_nxt = level_r[3];
            led_ctrl_pkg::CONFIG_ADDR:    rdata_nxt = config_r;
            led_ctrl_pkg::SRC_MAP_ADDR:   rdata_nxt = map_r;
            default:                      rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < 4; i++)
         begin
            duty_r[i]  <= led_ctrl_pkg::DUTY_RST;
            level_r[i] <= led_ctrl_pkg::LEVEL_RST;
         end
         enable_r    <= led_ctrl_pkg::CTRL_RST;
         config_r    <= led_ctrl_pkg::CTRL_RST;
         map_r       <= led_ctrl_pkg::MAP_RST;
         reg_rdata_o <= 8'h00;
      end
      else
      begin
         duty_r      <= duty_nxt;
         level_r     <= level_nxt;
         enable_r    <= enable_nxt;
         config_r    <= config_nxt;
         map_r       <= map_nxt;
         reg_rdata_o <= rdata_nxt;
      end
   end

   // Startup timers: pin settle and device-on settle
   logic [16:0] pin_cnt_r;
   logic [16:0] pin_cnt_nxt;
   logic [16:0] on_cnt_r;
   logic [16:0] on_cnt_nxt;
   logic        pin_ready;
   logic        dev_on;

   assign dev_on    = enable_r[led_ctrl_pkg::DEV_ON_BIT];
   assign pin_ready = pin_cnt_r == PIN_ON_LIM;

   always_comb
   begin
      pin_cnt_nxt = pin_cnt_r;
      on_cnt_nxt  = on_cnt_r;
      if (!pin_filt_r)
      begin
         pin_cnt_nxt = 17'h0;
      end
      else if (!pin_ready)
      begin
         pin_cnt_nxt = pin_cnt_r + 17'h1;
      end
      if (mode_r != led_ctrl_pkg::MODE_STARTUP)
      begin
         on_cnt_nxt = 17'h0;
      end
      else if (on_cnt_r != DEV_ON_LIM)
      begin
         on_cnt_nxt = on_cnt_r + 17'h1;
      end
   end

   // Mode sequencer
   always_comb
   begin
      mode_nxt = mode_r;
      case (mode_r)
         led_ctrl_pkg::MODE_RESET:
            mode_nxt = led_ctrl_pkg::MODE_STANDBY;
         led_ctrl_pkg::MODE_STANDBY:
            if (dev_on && pin_filt_r)
            begin
               mode_nxt = led_ctrl_pkg::MODE_STARTUP;
            end
         led_ctrl_pkg::MODE_STARTUP:
            if (on_cnt_r == DEV_ON_LIM && pin_ready && !heat_filt_r)
            begin
               mode_nxt = led_ctrl_pkg::MODE_NORMAL;
            end
         led_ctrl_pkg::MODE_NORMAL:
            if (heat_filt_r)
            begin
               mode_nxt = led_ctrl_pkg::MODE_STARTUP;
            end
            else if (power_save_req_i)
            begin
               mode_nxt = led_ctrl_pkg::MODE_SAVE;
            end
         led_ctrl_pkg::MODE_SAVE:
            if (heat_filt_r)
            begin
               mode_nxt = led_ctrl_pkg::MODE_STARTUP;
            end
            else if (!power_save_req_i)
            begin
               mode_nxt = led_ctrl_pkg::MODE_NORMAL;
            end
         default:
            mode_nxt = led_ctrl_pkg::MODE_RESET;
      endcase
      // Either enable low forces standby; soft reset passes through reset
      if (mode_r != led_ctrl_pkg::MODE_RESET && (!dev_on || !pin_filt_r))
      begin
         mode_nxt = led_ctrl_pkg::MODE_STANDBY;
      end
      if (soft_rst)
      begin
         mode_nxt = led_ctrl_pkg::MODE_RESET;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mode_r    <= led_ctrl_pkg::MODE_RESET;
         pin_cnt_r <= 17'h0;
         on_cnt_r  <= 17'h0;
      end
      else
      begin
         mode_r    <= mode_nxt;
         pin_cnt_r <= pin_cnt_nxt;
         on_cnt_r  <= on_cnt_nxt;
      end
   end

   // Duty period: prescaler sets step rate, counter free-runs
   logic [10:0] div_r;
   logic [10:0] div_nxt;
   logic [10:0] div_lim;
   logic [7:0]  period_r;
   logic [7:0]  period_nxt;

   assign div_lim = config_r[led_ctrl_pkg::FAST_RATE_BIT] ?
                    FAST_LIM : SLOW_LIM;

   always_comb
   begin
      div_nxt    = div_r + 11'h1;
      period_nxt = period_r;
      if (div_r >= div_lim)
      begin
         div_nxt    = 11'h0;
         period_nxt = period_r + 8'h1;
      end
   end

   // Source select per channel; direct engines reuse duty registers
   logic [7:0] eng_val[3];
   logic [7:0] sel_duty[4];
   logic [3:0] pwm_nxt;
   logic       active;

   assign active     = mode_r == led_ctrl_pkg::MODE_NORMAL;
   assign eng_val[0] = eng_direct_i[0] ? duty_r[0] : eng1_duty_i;
   assign eng_val[1] = eng_direct_i[1] ? duty_r[1] : eng2_duty_i;
   assign eng_val[2] = eng_direct_i[2] ? duty_r[2] : eng3_duty_i;

   for (genvar ch = 0; ch < 4; ch++)
   begin : g_chan
      always_comb
      begin
         case (map_r[2*ch +: 2])
            led_ctrl_pkg::SRC_REG:  sel_duty[ch] = duty_r[ch];
            led_ctrl_pkg::SRC_ENG1: sel_duty[ch] = eng_val[0];
            led_ctrl_pkg::SRC_ENG2: sel_duty[ch] = eng_val[1];
            led_ctrl_pkg::SRC_ENG3: sel_duty[ch] = eng_val[2];
            default:                sel_duty[ch] = duty_r[ch];
         endcase
         // Full scale never drops, so ffh is held on for the whole period
         pwm_nxt[ch] = active && (period_r < sel_duty[ch] ||
                                  sel_duty[ch] == 8'hff);
      end
   end

   // Sink codes pass as linear 0.1 mA steps; the analog side scales them
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         div_r              <= 11'h0;
         period_r           <= 8'h00;
         led_pwm_o          <= 4'h0;
         blue_sink_level_o  <= led_ctrl_pkg::LEVEL_RST;
         green_sink_level_o <= led_ctrl_pkg::LEVEL_RST;
         red_sink_level_o   <= led_ctrl_pkg::LEVEL_RST;
         white_sink_level_o <= led_ctrl_pkg::LEVEL_RST;
         analog_enable_o    <= 1'b0;
         op_mode_o          <= led_ctrl_pkg::MODE_RESET;
      end
      else
      begin
         div_r              <= div_nxt;
         period_r           <= period_nxt;
         led_pwm_o          <= pwm_nxt;
         blue_sink_level_o  <= level_r[0];
         green_sink_level_o <= level_r[1];
         red_sink_level_o   <= level_r[2];
         white_sink_level_o <= level_r[3];
         analog_enable_o    <= mode_nxt == led_ctrl_pkg::MODE_STARTUP ||
                               mode_nxt == led_ctrl_pkg::MODE_NORMAL;
         op_mode_o          <= mode_nxt;
      end
   end

endmodule

// [rtl/led_ctrl_pkg.sv]
// Purpose: Constants for the four-channel LED sink control block
// Assumes: 125 MHz reference clock, byte-wide register port
// Notes:   Channel order everywhere is blue, green, red, white
package led_ctrl_pkg;
   // Register offsets
   localparam logic [7:0] ENABLE_ADDR    = 8'h00;
   localparam logic [7:0] BLUE_DUTY_ADDR = 8'h02;
   localparam logic [7:0] GRN_DUTY_ADDR  = 8'h03;
   localparam logic [7:0] RED_DUTY_ADDR  = 8'h04;
   localparam logic [7:0] BLUE_LVL_ADDR  = 8'h05;
   localparam logic [7:0] GRN_LVL_ADDR   = 8'h06;
   localparam logic [7:0] RED_LVL_ADDR   = 8'h07;
   localparam logic [7:0] CONFIG_ADDR    = 8'h08;
   localparam logic [7:0] SOFT_RST_ADDR  = 8'h0d;
   localparam logic [7:0] WHT_DUTY_ADDR  = 8'h0e;
   localparam logic [7:0] WHT_LVL_ADDR   = 8'h0f;
   localparam logic [7:0] SRC_MAP_ADDR   = 8'h70;
   localparam logic [7:0] SOFT_RST_KEY   = 8'hff;

   // Field positions
   localparam int DEV_ON_BIT    = 6;
   localparam int FAST_RATE_BIT = 6;

   // Reset values
   localparam logic [7:0] LEVEL_RST = 8'haf;
   localparam logic [7:0] DUTY_RST  = 8'h00;
   localparam logic [7:0] MAP_RST   = 8'h00;
   localparam logic [7:0] CTRL_RST  = 8'h00;

   // Source selector encodings
   localparam logic [1:0] SRC_REG  = 2'h0;
   localparam logic [1:0] SRC_ENG1 = 2'h1;
   localparam logic [1:0] SRC_ENG2 = 2'h2;
   localparam logic [1:0] SRC_ENG3 = 2'h3;

   // Timing
   localparam int CLK_MHZ        = 125;
   localparam int CLK_HZ         = CLK_MHZ * 1000000;
   localparam int DEV_ON_US      = 500;
   localparam int PIN_ON_US      = 1000;
   localparam int DEV_ON_CYC     = DEV_ON_US * CLK_MHZ;
   localparam int PIN_ON_CYC     = PIN_ON_US * CLK_MHZ;
   localparam int DUTY_STEPS     = 256;
   localparam int SLOW_RATE_HZ   = 256;
   localparam int FAST_RATE_HZ   = 558;
   localparam int SLOW_DIV       = CLK_HZ / (SLOW_RATE_HZ * DUTY_STEPS);
   localparam int FAST_DIV       = CLK_HZ / (FAST_RATE_HZ * DUTY_STEPS);
   localparam int DLY_W          = 17;
   localparam int DIV_W          = 11;

   // Operating modes, one-hot
   typedef enum logic [4:0] {
      MODE_RESET   = 5'h01,
      MODE_STANDBY = 5'h02,
      MODE_STARTUP = 5'h04,
      MODE_NORMAL  = 5'h08,
      MODE_SAVE    = 5'h10
   } op_mode_e;
endpackage

// [verification/led_ctrl_chk.sv]
// Purpose: Port-level temporal checks for the LED mode and duty block
// Assumes: Pins held steady for several cycles around each change
// Notes:   Bound onto every instance of the control block
`timescale 1ns/100ps
module led_ctrl_chk #(
   parameter int DEV_ON_CYC = 20,
   parameter int PIN_ON_CYC = 40
) (
   input wire logic       ref_clk_i,
   input wire logic       rst_i,
   input wire logic       power_on_pin_i,
   input wire logic       overheat_cutoff_i,
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [3:0] led_pwm_o,
   input wire logic [7:0] blue_sink_level_o,
   input wire logic       analog_enable_o,
   input wire logic [4:0] op_mode_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   // Cycles spent in startup, to bound the early exit to normal
   int start_cnt_r;
   int start_cnt_nxt;
   always_comb
   begin
      start_cnt_nxt = (op_mode_o == 5'h04) ? start_cnt_r + 1 : 0;
   end
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         start_cnt_r <= 0;
      else
         start_cnt_r <= start_cnt_nxt;
   end

   // Pin filter settles within six cycles, so writes are taken
   sequence s_pin_up;
      power_on_pin_i [*6];
   endsequence
   sequence s_soft_rst;
      reg_wr_i && reg_addr_i == 8'h0d && reg_wdata_i == 8'hff;
   endsequence

   property p_rst_exit;
      $fell(rst_i) |-> op_mode_o == 5'h01 ##1 op_mode_o == 5'h02;
   endproperty
   a_rst_exit: assert property (p_rst_exit)
      else $error("mode after reset release not standby");
   property p_soft_rst;
      s_pin_up ##0 s_soft_rst |-> ##[1:2] (op_mode_o == 5'h01)
         ##1 (op_mode_o == 5'h02);
   endproperty
   a_soft_rst: assert property (p_soft_rst)
      else $error("soft reset did not pass through reset mode");
   property p_analog;
      $stable(op_mode_o) |-> analog_enable_o ==
         (op_mode_o == 5'h04 || op_mode_o == 5'h08);
   endproperty
   a_analog: assert property (p_analog)
      else $error("analog enable disagrees with mode");
   property p_start_len;
      (op_mode_o == 5'h08 && $past(op_mode_o) == 5'h04)
         |-> start_cnt_r >= DEV_ON_CYC - 1;
   endproperty
   a_start_len: assert property (p_start_len)
      else $error("normal reached before startup delay");
   property p_hot;
      overheat_cutoff_i [*8] |-> op_mode_o != 5'h08;
   endproperty
   a_hot: assert property (p_hot)
      else $error("normal mode while overheated");
   property p_pin_low;
      !power_on_pin_i [*8] |-> op_mode_o == 5'h02;
   endproperty
   a_pin_low: assert property (p_pin_low)
      else $error("not standby while pin low");
   property p_pwm_off;
      (op_mode_o != 5'h08) [*2] |-> led_pwm_o == 4'h0;
   endproperty
   a_pwm_off: assert property (p_pwm_off)
      else $error("outputs driven outside normal mode");
   property p_level_wr;
      s_pin_up ##0 (reg_wr_i && reg_addr_i == 8'h05)
         |-> ##2 blue_sink_level_o == $past(reg_wdata_i, 2);
   endproperty
   a_level_wr: assert property (p_level_wr)
      else $error("sink level output missed a write");
   property p_unmapped;
      reg_rd_i && (reg_addr_i == 8'h0d || reg_addr_i == 8'h80)
         |=> reg_rdata_o == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("write-only or unmapped read not zero");
endmodule

bind led_channel_mode_pwm_control led_ctrl_chk #(
   .DEV_ON_CYC(DEV_ON_CYC),
   .PIN_ON_CYC(PIN_ON_CYC)
) chk_inst (
   .ref_clk_i(ref_clk_i),
   .rst_i(rst_i),
   .power_on_pin_i(power_on_pin_i),
   .overheat_cutoff_i(overheat_cutoff_i),
   .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i),
   .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i),
   .reg_rdata_o(reg_rdata_o),
   .led_pwm_o(led_pwm_o),
   .blue_sink_level_o(blue_sink_level_o),
   .analog_enable_o(analog_enable_o),
   .op_mode_o(op_mode_o)
);

// [verification/host_model.sv]
// Purpose: Host side of the register port and the enable pin
// Assumes: One byte transfer at a time, strobes launched on rising edge
// Notes:   Released address and data lines show the inverse pattern
`timescale 1ns/100ps
module host_model #(
   parameter int PIN_WAIT = 40,
   parameter int DEV_WAIT = 20
) (
   input  wire logic       ref_clk_i,
   output logic            pin_o,
   output logic            wr_o,
   output logic            rd_o,
   output logic      [7:0] addr_o,
   output logic      [7:0] wdata_o,
   input  wire logic [7:0] rdata_i
);
   initial
   begin
      pin_o = 1'b0;
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
   end

   // Host holds off commands after raising the pin
   task automatic set_pin(input logic v);
      @(posedge ref_clk_i);
      pin_o <= v;
      if (v)
         repeat (PIN_WAIT + 8) @(posedge ref_clk_i);
   endtask

   // One write strobe, lines released to a stale-looking pattern
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      wr_o <= 1'b1;
      addr_o <= a;
      wdata_o <= d;
      @(posedge ref_clk_i);
      wr_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask

   // Read data lands on the taking edge, picked up half a cycle on
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk_i);
      rd_o <= 1'b1;
      addr_o <= a;
      @(posedge ref_clk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      @(negedge ref_clk_i);
      d = rdata_i;
   endtask

   // Device-on bit, then the startup wait before relying on it
   task automatic chip_on;
      wr(8'h00, 8'h40);
      repeat (DEV_WAIT) @(posedge ref_clk_i);
   endtask
endmodule

// [verification/tb_top.sv]
// Purpose: Self-checking bench for the LED mode and duty block
// Assumes: Shortened startup counts of 20 and 40 cycles
// Notes:   Duties limited to 00 and ff so counter phase never matters
`timescale 1ns/100ps
module tb_top;
   logic       ref_clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic       hot;
   logic       save;
   logic [7:0] eng [3];
   logic [2:0] direct;
   logic       pin, wr, rd;
   logic [7:0] addr, wdata, rdata, rv, map;
   logic [7:0] lvl [4];
   logic [7:0] duty [4];
   logic [7:0] lv_exp [4];
   logic [3:0] pwm;
   logic       analog;
   logic [4:0] mode;
   int         fails = 0;
   int         tests_run = 0;
   localparam logic [7:0] DADR [4] = '{8'h02, 8'h03, 8'h04, 8'h0e};
   localparam logic [7:0] LADR [4] = '{8'h05, 8'h06, 8'h07, 8'h0f};

   always #4 ref_clk_i = ~ref_clk_i;

   host_model #(.PIN_WAIT(40), .DEV_WAIT(20)) host_model_inst (
      .ref_clk_i(ref_clk_i), .pin_o(pin), .wr_o(wr), .rd_o(rd),
      .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata));
   led_channel_mode_pwm_control #(.DEV_ON_CYC(20), .PIN_ON_CYC(40))
   led_channel_mode_pwm_control_inst (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .power_on_pin_i(pin),
      .overheat_cutoff_i(hot), .power_save_req_i(save),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .eng1_duty_i(eng[0]), .eng2_duty_i(eng[1]),
      .eng3_duty_i(eng[2]), .eng_direct_i(direct), .reg_rdata_o(rdata),
      .led_pwm_o(pwm), .blue_sink_level_o(lvl[0]),
      .green_sink_level_o(lvl[1]), .red_sink_level_o(lvl[2]),
      .white_sink_level_o(lvl[3]), .analog_enable_o(analog),
      .op_mode_o(mode));

   // Expected outputs from map, duties, engines and direct flags
   function automatic logic [3:0] exp_pwm(input logic [7:0] m);
      logic [1:0] s;
      logic [7:0] d;
      exp_pwm = 4'h0;
      for (int i = 0; i < 4; i++)
      begin
         s = m[2*i +: 2];
         if (s == 2'h0)
            d = duty[i];
         else
            d = direct[s-1] ? duty[s-1] : eng[s-1];
         exp_pwm[i] = (d == 8'hff);
      end
   endfunction

   task automatic chk(input string what, input logic [7:0] e,
                      input logic [7:0] g);
      tests_run++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", what, e, g);
         fails++;
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      host_model_inst.rd(a, rv);
      chk("reg_rdata", e, rv);
   endtask

   // Bounded poll, so a stuck sequencer shows up as a mismatch
   task automatic wait_mode(input logic [4:0] m);
      int n;
      n = 0;
      while (mode !== m && n < 400)
      begin
         @(negedge ref_clk_i);
         n++;
      end
      chk("op_mode", {3'h0, m}, {3'h0, mode});
   endtask

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Watchdog sized well above the expected several hundred cycles
   initial
   begin
      #(30000 * 8);
      fails++;
      stop_test();
   end

   // Main sequence
   initial
   begin
      rv = $urandom(97528);
      // Side inputs start idle; each scenario moves them on a rising edge
      hot    <= 1'b0;
      save   <= 1'b0;
      eng    <= '{8'h00, 8'h00, 8'h00};
      direct <= 3'h0;
      repeat (20) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      wait_mode(5'h02);
      for (int i = 0; i < 4; i++)
      begin
         rd_chk(LADR[i], 8'haf);
         rd_chk(DADR[i], 8'h00);
      end
      rd_chk(8'h70, 8'h00);
      rd_chk(8'h0d, 8'h00);
      rd_chk(8'h80, 8'h00);
      host_model_inst.set_pin(1'b1);
      host_model_inst.wr(8'h02, 8'hff);
      host_model_inst.chip_on();
      wait_mode(5'h04);
      chk("led_pwm_start", 8'h00, {4'h0, pwm});
      wait_mode(5'h08);
      repeat (4) @(negedge ref_clk_i);
      chk("led_pwm_first", 8'h01, {4'h0, pwm});
      chk("analog", 8'h01, {7'h0, analog});
      for (int k = 0; k < 14; k++)
      begin
         for (int i = 0; i < 4; i++)
         begin
            duty[i] = $urandom_range(1, 0) ? 8'hff : 8'h00;
            host_model_inst.wr(DADR[i], duty[i]);
         end
         map = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
         host_model_inst.wr(8'h70, map);
         @(posedge ref_clk_i);
         for (int j = 0; j < 3; j++)
            eng[j] <= $urandom_range(1, 0) ? 8'hff : 8'h00;
         direct <= (k == 1) ? 3'h7 : 3'($urandom);
         repeat (4) @(negedge ref_clk_i);
         chk("led_pwm", {4'h0, exp_pwm(map)}, {4'h0, pwm});
         rd_chk(8'h70, map);
      end
      for (int i = 0; i < 4; i++)
      begin
         lv_exp[i] = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
         host_model_inst.wr(LADR[i], lv_exp[i]);
         rd_chk(LADR[i], lv_exp[i]);
         chk("sink_level", lv_exp[i], lvl[i]);
      end
      host_model_inst.wr(8'h08, 8'h40);
      rd_chk(8'h08, 8'h40);
      @(posedge ref_clk_i);
      hot <= 1'b1;
      wait_mode(5'h04);
      repeat (30) @(negedge ref_clk_i);
      chk("op_mode_hot", 8'h04, {3'h0, mode});
      @(posedge ref_clk_i);
      hot <= 1'b0;
      wait_mode(5'h08);
      @(posedge ref_clk_i);
      save <= 1'b1;
      wait_mode(5'h10);
      chk("analog_save", 8'h00, {7'h0, analog});
      rd_chk(LADR[2], lv_exp[2]);
      @(posedge ref_clk_i);
      save <= 1'b0;
      wait_mode(5'h08);
      host_model_inst.set_pin(1'b0);
      wait_mode(5'h02);
      host_model_inst.wr(LADR[0], 8'h33);
      host_model_inst.set_pin(1'b1);
      chk("op_mode_pin", 8'h02, {3'h0, mode});
      rd_chk(LADR[0], lv_exp[0]);
      host_model_inst.chip_on();
      wait_mode(5'h08);
      host_model_inst.wr(8'h0d, 8'h12);
      rd_chk(LADR[3], lv_exp[3]);
      host_model_inst.wr(8'h0d, 8'hff);
      wait_mode(5'h02);
      for (int i = 0; i < 4; i++)
      begin
         rd_chk(LADR[i], 8'haf);
         rd_chk(DADR[i], 8'h00);
      end
      rd_chk(8'h70, 8'h00);
      stop_test();
   end
endmodule
